// *** sms_mode_switch.sv ***
// Control mode switching, speed source selection and forced stop sequence.
// Assumes contact pins are asynchronous; analog and feedback words are on clk.
// Functional notes
// - Without third select, two bits pick analog or internal speeds one to three.
// - With third select enabled, 000 is analog, 001-111 internal speeds one-seven.
// - Speed changes while running ramp with acceleration and deceleration steps.
// - Mode digit 3 enters speed/torque switching.
// - Speed/torque switching follows the control switch at once, any speed.
// - Speed mode with both start inputs off ramps to stop by deceleration.
// - Torque mode limit: first select bit picks analog or internal limit one.
// - Mode digit 5 enters torque/position switching.
// - Torque/position change happens only in the zero-speed state.
// - Position to torque change clears the droop pulse count.
// - Toggle above zero speed leaves the mode unchanged, even later.
// - Forced stop input off decelerates with the forced-stop step.
// - Below zero-speed threshold during forced stop: base cut, dynamic brake.
// - Warning code shows for the whole forced-stop sequence.
// - No forced-stop deceleration while in torque control.
// - Stroke limit during forced stop: policy 0 sudden stop, 1 continue.
// - Torque/position toggle changes mode only if zero-speed flag already set at toggle.
// - Torque/position toggle before zero-speed flag is ignored even after flag sets.
`timescale 1ns/1ps
module sms_mode_switch
    import sms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [15:0] rdData,
    input wire logic forwardStartInput,
    input wire logic reverseStartInput,
    input wire logic [2:0] speedSelect,
    input wire logic controlSwitchInput,
    input wire logic forcedStopInput,
    input wire logic forwardStrokeLimit,
    input wire logic reverseStrokeLimit,
    input wire logic signed [15:0] analogSpeedCommand,
    input wire logic [15:0] analogSpeedLimit,
    input wire logic signed [15:0] motorSpeed,
    output logic signed [15:0] speedCommand,
    output logic [15:0] speedLimit,
    output logic [1:0] controlMode,
    output logic droopClear,
    output logic baseOn,
    output logic dynamicBrake,
    output logic [7:0] forcedStopWarning,
    output logic zeroSpeedFlag
);
    // ****************************************************************
    // Contact synchroniser
    // ****************************************************************
    logic [NUM_PINS-1:0] pinMeta_r;
    logic [NUM_PINS-1:0] pinSync_r;
    logic [NUM_PINS-1:0] pinsRaw;

    assign pinsRaw = {reverseStrokeLimit, forwardStrokeLimit, forcedStopInput,
                      controlSwitchInput, speedSelect, reverseStartInput, forwardStartInput};

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Forced stop contact idles high; resetting it low would start a false stop
            pinMeta_r <= NUM_PINS'(1 << PIN_EM2);
            pinSync_r <= NUM_PINS'(1 << PIN_EM2);
        end
        else
        begin
            pinMeta_r <= pinsRaw;
            pinSync_r <= pinMeta_r;
        end
    end

    logic st1;
    logic st2;
    logic [2:0] sp;
    logic control_switch_input;
    logic em2;
    logic strokeHit;

    assign st1 = pinSync_r[PIN_ST1];
    assign st2 = pinSync_r[PIN_ST2];
    assign sp = pinSync_r[PIN_SP_LSB +: 3];
    assign control_switch_input = pinSync_r[PIN_LOP];
    assign em2 = pinSync_r[PIN_EM2];
    assign strokeHit = pinSync_r[PIN_LSP] | pinSync_r[PIN_LSN];

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] ctrl_r, accel_r, decel_r, fstop_r, zthr_r;
    logic [15:0] ctrl_nxt, accel_nxt, decel_nxt, fstop_nxt, zthr_nxt;
    logic [15:0] intSpeed_r [SMS_NUM_INT];
    logic [15:0] intSpeed_nxt [SMS_NUM_INT];
    logic [SMS_NUM_INT*16-1:0] intFlat;
    logic [15:0] rdData_r, rdData_nxt, statusWord;
    sms_mode_e mode_r;
    sms_stop_e stop_r;
    logic signed [15:0] rampOut;
    logic zeroSpeed_r;

    genvar gi;
    generate
        for (gi = 0; gi < SMS_NUM_INT; gi++)
        begin : g_int
            assign intFlat[gi*16 +: 16] = intSpeed_r[gi];
        end
    endgenerate

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        accel_nxt = accel_r;
        decel_nxt = decel_r;
        fstop_nxt = fstop_r;
        zthr_nxt = zthr_r;
        intSpeed_nxt = intSpeed_r;
        statusWord = '0;
        statusWord[STAT_MODE_LSB +: 2] = mode_r;
        statusWord[STAT_ZSP_BIT] = zeroSpeed_r;
        statusWord[STAT_BASE_BIT] = baseOn;
        statusWord[STAT_DB_BIT] = dynamicBrake;
        statusWord[STAT_WARN_BIT] = (stop_r != STOP_RUN);
        statusWord[STAT_STOP_LSB +: 2] = stop_r;
        if (wrEn)
        begin
            if (addr == ADDR_CTRL) ctrl_nxt = wrData;
            if (addr == ADDR_ACCEL) accel_nxt = wrData;
            if (addr == ADDR_DECEL) decel_nxt = wrData;
            if (addr == ADDR_FSTOP) fstop_nxt = wrData;
            if (addr == ADDR_ZTHR) zthr_nxt = wrData;
            if (addr >= ADDR_INT1 && addr < ADDR_STATUS)
                intSpeed_nxt[3'(addr - ADDR_INT1)] = wrData;
        end
        rdData_nxt = '0;
        if (rdEn)
        begin
            unique case (addr)
                ADDR_CTRL: rdData_nxt = ctrl_r;
                ADDR_ACCEL: rdData_nxt = accel_r;
                ADDR_DECEL: rdData_nxt = decel_r;
                ADDR_FSTOP: rdData_nxt = fstop_r;
                ADDR_ZTHR: rdData_nxt = zthr_r;
                ADDR_STATUS: rdData_nxt = statusWord;
                ADDR_SPEED: rdData_nxt = rampOut;
                default:
                begin
                    if (addr >= ADDR_INT1 && addr < ADDR_STATUS)
                        rdData_nxt = intSpeed_r[3'(addr - ADDR_INT1)];
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_r <= RST_CTRL;
            accel_r <= RST_STEP;
            decel_r <= RST_STEP;
            fstop_r <= RST_STEP;
            zthr_r <= RST_ZTHR;
            for (int i = 0; i < SMS_NUM_INT; i++) intSpeed_r[i] <= RST_INT;
            rdData_r <= '0;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            accel_r <= accel_nxt;
            decel_r <= decel_nxt;
            fstop_r <= fstop_nxt;
            zthr_r <= zthr_nxt;
            intSpeed_r <= intSpeed_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    assign rdData = rdData_r;

    // ****************************************************************
    // Control mode switching
    // ****************************************************************
    logic [3:0] modeDigit;
    logic lopPrev_r, lopTog;
    sms_mode_e mode_nxt;
    logic droop_r, droop_nxt, zeroSpeed_nxt;

    assign modeDigit = ctrl_r[CTRL_MODE_LSB +: 4];
    assign lopTog = control_switch_input != lopPrev_r;

    always_comb
    begin
        mode_nxt = mode_r;
        zeroSpeed_nxt = sms_abs(motorSpeed) < zthr_r;
        if (modeDigit == MODE_SPD_TRQ)
        begin
            mode_nxt = control_switch_input ? SMS_TORQUE : SMS_SPEED;
        end
        else if (modeDigit == MODE_TRQ_POS)
        begin
            if (mode_r == SMS_SPEED)
            begin
                mode_nxt = control_switch_input ? SMS_POSITION : SMS_TORQUE;
            end
            else if (lopTog && zeroSpeed_r)
            begin
                mode_nxt = control_switch_input ? SMS_POSITION : SMS_TORQUE;
            end
        end
        else
        begin
            mode_nxt = SMS_SPEED;
        end
        droop_nxt = (mode_r == SMS_POSITION) && (mode_nxt == SMS_TORQUE);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_r <= SMS_SPEED;
            lopPrev_r <= 1'b0;
            droop_r <= 1'b0;
            zeroSpeed_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            lopPrev_r <= control_switch_input;
            droop_r <= droop_nxt;
            zeroSpeed_r <= zeroSpeed_nxt;
        end
    end

    // ****************************************************************
    // Forced stop sequence
    // ****************************************************************
    sms_stop_e stop_nxt;
    logic baseOn_r, dynBrake_r;
    logic [7:0] warn_r;

    always_comb
    begin
        stop_nxt = stop_r;
        unique case (stop_r)
            STOP_RUN:
            begin
                if (!em2)
                    stop_nxt = (mode_r == SMS_TORQUE) ? STOP_CUT : STOP_DECEL;
            end
            STOP_DECEL:
            begin
                if (zeroSpeed_r)
                    stop_nxt = STOP_CUT;
                else if (strokeHit && !ctrl_r[CTRL_POLICY_BIT])
                    stop_nxt = STOP_SUDDEN;
            end
            STOP_SUDDEN:
            begin
                if (zeroSpeed_r)
                    stop_nxt = STOP_CUT;
            end
            STOP_CUT:
            begin
                if (em2)
                    stop_nxt = STOP_RUN;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stop_r <= STOP_RUN;
            baseOn_r <= 1'b0;
            dynBrake_r <= 1'b0;
            warn_r <= NO_WARN;
        end
        else
        begin
            stop_r <= stop_nxt;
            baseOn_r <= (stop_nxt != STOP_CUT);
            dynBrake_r <= (stop_nxt == STOP_CUT);
            warn_r <= (stop_nxt != STOP_RUN) ? WARN_CODE : NO_WARN;
        end
    end

    // ****************************************************************
    // Speed command and speed limit
    // ****************************************************************
    logic [15:0] selSpeed;
    logic signed [15:0] target;
    logic [15:0] rampAccel, rampDecel;
    logic [15:0] limit_r, limit_nxt;

    sms_speed_sel u_sel (
        .sel(sp),
        .sp3En(ctrl_r[CTRL_SP3_BIT]),
        .analogVal(analogSpeedCommand),
        .intFlat(intFlat),
        .selVal(selSpeed)
    );

    always_comb
    begin
        target = 16'sh0000;
        rampAccel = accel_r;
        rampDecel = decel_r;
        if (stop_r == STOP_DECEL)
        begin
            rampAccel = fstop_r;
            rampDecel = fstop_r;
        end
        else if (stop_r == STOP_RUN && mode_r == SMS_SPEED)
        begin
            if (st1 && !st2)
                target = $signed(selSpeed);
            else if (st2 && !st1)
                target = 16'(-$signed(selSpeed));
        end
        limit_nxt = sp[0] ? intSpeed_r[0] : analogSpeedLimit;
    end

    sms_ramp u_ramp (
        .clk(clk),
        .rst_n(rst_n),
        .target(target),
        .accelStep(rampAccel),
        .decelStep(rampDecel),
        .sudden(stop_r == STOP_SUDDEN || stop_r == STOP_CUT),
        .rampOut(rampOut)
    );

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            limit_r <= '0;
        else
            limit_r <= limit_nxt;
    end

    assign speedCommand = rampOut;
    assign speedLimit = limit_r;
    assign controlMode = mode_r;
    assign droopClear = droop_r;
    assign baseOn = baseOn_r;
    assign dynamicBrake = dynBrake_r;
    assign forcedStopWarning = warn_r;
    assign zeroSpeedFlag = zeroSpeed_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_st_follow: assert property (@(posedge clk) disable iff (!rst_n)
        modeDigit == MODE_SPD_TRQ |=> mode_r == ($past(control_switch_input) ? SMS_TORQUE : SMS_SPEED))
        else $error("speed/torque mode does not follow switch");
    a_tp_hold_moving: assert property (@(posedge clk) disable iff (!rst_n)
        modeDigit == MODE_TRQ_POS && mode_r != SMS_SPEED && lopTog && !zeroSpeed_r
        |=> $stable(mode_r))
        else $error("mode changed while motor moving");
    a_tp_switch_zero: assert property (@(posedge clk) disable iff (!rst_n)
        modeDigit == MODE_TRQ_POS && mode_r != SMS_SPEED && lopTog && zeroSpeed_r
        |=> mode_r == ($past(control_switch_input) ? SMS_POSITION : SMS_TORQUE))
        else $error("mode not switched at zero speed");
    a_droop_clear: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == SMS_TORQUE && $past(mode_r) == SMS_POSITION |-> droopClear)
        else $error("droop not cleared on position to torque");
    a_cut_brake: assert property (@(posedge clk) disable iff (!rst_n)
        stop_r == STOP_DECEL && zeroSpeed_r |=> !baseOn && dynamicBrake)
        else $error("base not cut below zero speed");
    a_warn_shown: assert property (@(posedge clk) disable iff (!rst_n)
        stop_r != STOP_RUN |-> forcedStopWarning == WARN_CODE)
        else $error("warning missing during forced stop");
    a_torque_no_decel: assert property (@(posedge clk) disable iff (!rst_n)
        stop_r == STOP_RUN && mode_r == SMS_TORQUE && !em2 |=> stop_r == STOP_CUT)
        else $error("forced deceleration in torque mode");
    a_limit_policy: assert property (@(posedge clk) disable iff (!rst_n)
        stop_r == STOP_DECEL && !zeroSpeed_r && strokeHit
        |=> stop_r == ($past(ctrl_r[CTRL_POLICY_BIT]) ? STOP_DECEL : STOP_SUDDEN))
        else $error("stroke limit policy not applied");
    a_start_off_stop: assert property (@(posedge clk) disable iff (!rst_n)
        mode_r == SMS_SPEED && !st1 && !st2 |-> target == 16'sh0000)
        else $error("speed target not zero with starts off");
    a_sel_analog: assert property (@(posedge clk) disable iff (!rst_n)
        sp[1:0] == 2'b00 && (!ctrl_r[CTRL_SP3_BIT] || !sp[2])
        |-> selSpeed == analogSpeedCommand)
        else $error("analog speed not selected");
endmodule

// *** sms_pkg.sv ***
// Shared constants, types and helpers for the servo mode switch block.
// Assumes one 50 MHz clock and a plain register port with 16-bit data.
package sms_pkg;
    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam int SMS_DW = 16;
    localparam int SMS_NUM_INT = 7;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_ACCEL = 4'h1;
    localparam logic [3:0] ADDR_DECEL = 4'h2;
    localparam logic [3:0] ADDR_FSTOP = 4'h3;
    localparam logic [3:0] ADDR_ZTHR = 4'h4;
    localparam logic [3:0] ADDR_INT1 = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam logic [3:0] ADDR_SPEED = 4'hD;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SP3_BIT = 4;
    localparam int CTRL_POLICY_BIT = 5;
    localparam logic [3:0] MODE_SPD_TRQ = 4'h3;
    localparam logic [3:0] MODE_TRQ_POS = 4'h5;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_ZSP_BIT = 2;
    localparam int STAT_BASE_BIT = 3;
    localparam int STAT_DB_BIT = 4;
    localparam int STAT_WARN_BIT = 5;
    localparam int STAT_STOP_LSB = 6;
    // ****************************************************************
    // Reset values and codes
    // ****************************************************************
    localparam logic [15:0] RST_CTRL = 16'h0000;
    localparam logic [15:0] RST_STEP = 16'h0001;
    localparam logic [15:0] RST_ZTHR = 16'h0032;
    localparam logic [15:0] RST_INT = 16'h0000;
    localparam logic [7:0] WARN_CODE = 8'hE6;
    localparam logic [7:0] NO_WARN = 8'h00;
    // ****************************************************************
    // Contact input positions
    // ****************************************************************
    localparam int NUM_PINS = 9;
    localparam int PIN_ST1 = 0;
    localparam int PIN_ST2 = 1;
    localparam int PIN_SP_LSB = 2;
    localparam int PIN_LOP = 5;
    localparam int PIN_EM2 = 6;
    localparam int PIN_LSP = 7;
    localparam int PIN_LSN = 8;

    typedef enum logic [1:0] {
        SMS_SPEED = 2'b00,
        SMS_TORQUE = 2'b01,
        SMS_POSITION = 2'b10
    } sms_mode_e;

    typedef enum logic [1:0] {
        STOP_RUN = 2'b00,
        STOP_DECEL = 2'b01,
        STOP_SUDDEN = 2'b10,
        STOP_CUT = 2'b11
    } sms_stop_e;

    function automatic logic [15:0] sms_abs(input logic signed [15:0] v);
        sms_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction
endpackage

// *** sms_speed_sel.sv ***
// Speed source selector: analog value or one of seven internal speeds.
// Assumes the select bits are already synchronised.
`timescale 1ns/1ps
module sms_speed_sel
    import sms_pkg::*;
(
    input wire logic [2:0] sel,
    input wire logic sp3En,
    input wire logic [15:0] analogVal,
    input wire logic [SMS_NUM_INT*16-1:0] intFlat,
    output logic [15:0] selVal
);
    logic [2:0] idx;

    always_comb
    begin
        idx = sp3En ? sel : {1'b0, sel[1:0]};
        if (idx == 3'h0)
        begin
            selVal = analogVal;
        end
        else
        begin
            selVal = intFlat[(int'(idx) - 1) * 16 +: 16];
        end
    end
endmodule

// *** sms_ramp.sv ***
// Speed ramp: moves the output toward a target by a step each cycle.
// Assumes the step values are nonzero; a zero step freezes the ramp.
`timescale 1ns/1ps
module sms_ramp
    import sms_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [15:0] target,
    input wire logic [15:0] accelStep,
    input wire logic [15:0] decelStep,
    input wire logic sudden,
    output logic signed [15:0] rampOut
);
    logic signed [15:0] ramp_r;
    logic signed [15:0] ramp_nxt;
    logic [15:0] step;
    logic signed [16:0] diff;

    assign rampOut = ramp_r;

    always_comb
    begin
        // Growing magnitude uses the acceleration step, shrinking the deceleration one
        step = (sms_abs(target) > sms_abs(ramp_r)) ? accelStep : decelStep;
        diff = 17'(target) - 17'(ramp_r);
        if (sudden)
        begin
            ramp_nxt = 16'sh0000;
        end
        else if (diff > $signed({1'b0, step}))
        begin
            ramp_nxt = 16'(ramp_r + $signed(step));
        end
        else if (diff < -$signed({1'b0, step}))
        begin
            ramp_nxt = 16'(ramp_r - $signed(step));
        end
        else
        begin
            ramp_nxt = target;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ramp_r <= 16'sh0000;
        end
        else
        begin
            ramp_r <= ramp_nxt;
        end
    end
endmodule

// *** sms_motor_model.sv ***
// Far-side model: a motor whose speed follows the command one cycle late.
// Assumes the testbench may pin the speed to a fixed value for interlock tests.
`timescale 1ns/1ps
module sms_motor_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic signed [15:0] speedCommand,
    input wire logic pinSpeed,
    input wire logic signed [15:0] pinValue,
    output logic signed [15:0] motorSpeed
);
    logic signed [15:0] speed_r;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            speed_r <= 16'sh0000;
        else
            speed_r <= speedCommand;
    end

    assign motorSpeed = pinSpeed ? pinValue : speed_r;
endmodule

// *** tb_sms_mode_switch.sv ***
// Self-checking bench for the mode switch and forced stop block.
// Assumes the design asserts its own rules; the motor model closes the loop.
`timescale 1ns/1ps
module tb_sms_mode_switch
    import sms_pkg::*;
;
    logic clk, rst_n, wrEn, rdEn, fwd, rev, sw, em2, forward_stroke_limit, reverse_stroke_limit, pinSpeed;
    logic [3:0] addr;
    logic [15:0] wrData, rdData, aLim, speedLimit;
    logic [2:0] sel;
    logic signed [15:0] aCmd, motorSpeed, speedCommand, pinValue;
    logic [1:0] controlMode;
    logic droopClear, baseOn, dynamicBrake, zero_speed_flag;
    logic [7:0] warn;
    logic [15:0] intSpeed [1:7];
    int error_cnt = 0;
    int n_checks = 0;
    int droopCnt = 0;
    int droopBase = 0;

    sms_mode_switch sms_mode_switch_i (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .forwardStartInput(fwd), .reverseStartInput(rev), .speedSelect(sel),
        .controlSwitchInput(sw), .forcedStopInput(em2), .forwardStrokeLimit(forward_stroke_limit),
        .reverseStrokeLimit(reverse_stroke_limit), .analogSpeedCommand(aCmd), .analogSpeedLimit(aLim),
        .motorSpeed(motorSpeed), .speedCommand(speedCommand), .speedLimit(speedLimit),
        .controlMode(controlMode), .droopClear(droopClear), .baseOn(baseOn),
        .dynamicBrake(dynamicBrake), .forcedStopWarning(warn), .zeroSpeedFlag(zero_speed_flag));

    sms_motor_model sms_motor_model_i (.clk(clk), .rst_n(rst_n),
        .speedCommand(speedCommand), .pinSpeed(pinSpeed), .pinValue(pinValue),
        .motorSpeed(motorSpeed));

    // ****************************************************************
    // Clock, helpers and checks
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (droopClear === 1'b1)
            droopCnt <= droopCnt + 1;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrEn <= 1'b1;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        chk(nm, exp, rdData);
    endtask

    // Waits for the brake with a bound, so a stuck sequence is reported
    task automatic wait_brake;
        int k;
        for (k = 0; k < 3000 && dynamicBrake !== 1'b1; k++)
            cyc(1);
        chk("brake wait", 16'h0001, 16'(k < 3000));
    endtask

    function automatic logic [15:0] exp_cmd(input logic [2:0] s, input logic e3);
        logic [2:0] k;
        k = e3 ? s : {1'b0, s[1:0]};
        exp_cmd = (k == 3'h0) ? aCmd : intSpeed[k];
    endfunction

    initial
    begin
        #(20 * 30000);
        error_cnt++;
        print_verdict();
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial
    begin
        void'($urandom(68117));
        {rst_n, wrEn, rdEn, fwd, rev, sw, forward_stroke_limit, reverse_stroke_limit, pinSpeed} = '0;
        em2 = 1'b1;
        addr = 4'h0;
        wrData = 16'h0000;
        sel = 3'h0;
        aCmd = 16'sh0000;
        aLim = 16'h0000;
        pinValue = 16'sh0000;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_CTRL, RST_CTRL, "ctrl reset");
        rd(ADDR_ZTHR, RST_ZTHR, "threshold reset");
        rd(ADDR_ACCEL, RST_STEP, "accel reset");
        rd(4'hE, 16'h0000, "unmapped");
        $display("test reset done");

        wr(ADDR_ACCEL, 16'h7FFF);
        wr(ADDR_DECEL, 16'h7FFF);
        for (int i = 1; i <= 7; i++)
        begin
            intSpeed[i] = 16'($urandom_range(16'h3FFF, 16'h0100));
            wr(ADDR_INT1 + 4'(i - 1), intSpeed[i]);
        end
        rd(ADDR_INT1 + 4'h6, intSpeed[7], "internal seven");
        fwd <= 1'b1;
        for (int j = 0; j < 16; j++)
        begin
            wr(ADDR_CTRL, 16'(j[3]) << CTRL_SP3_BIT);
            sel <= j[2:0];
            aCmd <= 16'($urandom_range(16'h3FFF, 16'h0100));
            aLim <= 16'($urandom);
            cyc(12);
            chk("command", exp_cmd(j[2:0], j[3]), speedCommand);
            chk("limit", j[0] ? intSpeed[1] : aLim, speedLimit);
        end
        $display("test speed select done");

        wr(ADDR_CTRL, 16'h0003);
        sw <= 1'b1;
        cyc(4);
        chk("mode", 16'(SMS_TORQUE), 16'(controlMode));
        sw <= 1'b0;
        cyc(4);
        chk("mode", 16'(SMS_SPEED), 16'(controlMode));
        fwd <= 1'b0;
        cyc(12);
        chk("stopped", 16'h0000, speedCommand);
        $display("test speed torque done");

        pinSpeed <= 1'b1;
        pinValue <= 16'sh0400;
        wr(ADDR_CTRL, 16'h0005);
        cyc(4);
        chk("mode", 16'(SMS_TORQUE), 16'(controlMode));
        sw <= 1'b1;
        cyc(6);
        chk("mode", 16'(SMS_TORQUE), 16'(controlMode));
        pinValue <= 16'sh0000;
        cyc(6);
        chk("zero speed", 16'h0001, 16'(zero_speed_flag));
        chk("mode", 16'(SMS_TORQUE), 16'(controlMode));
        sw <= 1'b0;
        cyc(6);
        sw <= 1'b1;
        cyc(6);
        chk("mode", 16'(SMS_POSITION), 16'(controlMode));
        droopBase = droopCnt;
        sw <= 1'b0;
        cyc(6);
        chk("mode", 16'(SMS_TORQUE), 16'(controlMode));
        chk("droop clears", 16'h0001, 16'(droopCnt - droopBase));
        $display("test torque position done");

        pinSpeed <= 1'b0;
        fwd <= 1'b1;
        sel <= 3'h1;
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_FSTOP, 16'h0010);
        cyc(20);
        em2 <= 1'b0;
        cyc(4);
        chk("warning", 16'(WARN_CODE), 16'(warn));
        chk("base during decel", 16'h0001, 16'(baseOn));
        chk("decel step", intSpeed[1] - 16'h0010, speedCommand);
        wait_brake();
        chk("base cut", 16'h0000, 16'(baseOn));
        rd(ADDR_STATUS, 16'h00F4, "status in cut");
        chk("slow", 16'h0001, 16'(motorSpeed < $signed(RST_ZTHR)));
        chk("warning", 16'(WARN_CODE), 16'(warn));
        em2 <= 1'b1;
        cyc(5);
        chk("base back", 16'h0001, 16'(baseOn));
        chk("warning off", 16'(NO_WARN), 16'(warn));
        $display("test forced stop done");

        sel <= 3'h0;
        aCmd <= 16'sh0200;
        for (int p = 0; p < 2; p++)
        begin
            wr(ADDR_CTRL, 16'(p) << CTRL_POLICY_BIT);
            wr(ADDR_FSTOP, 16'h0001);
            cyc(20);
            em2 <= 1'b0;
            cyc(8);
            forward_stroke_limit <= 1'b1;
            cyc(6);
            chk("stroke policy", 16'(p), 16'(speedCommand != 16'sh0000));
            forward_stroke_limit <= 1'b0;
            wait_brake();
            em2 <= 1'b1;
            cyc(5);
        end
        $display("test stroke limit done");

        pinSpeed <= 1'b1;
        pinValue <= 16'sh0400;
        wr(ADDR_CTRL, 16'h0003);
        sw <= 1'b1;
        cyc(6);
        em2 <= 1'b0;
        cyc(6);
        chk("torque stop base", 16'h0000, 16'(baseOn));
        chk("torque stop brake", 16'h0001, 16'(dynamicBrake));
        em2 <= 1'b1;
        cyc(6);
        $display("test torque stop done");
        print_verdict();
    end
endmodule
